// *** ctoc_consts.vh ***
// offsets, field layouts, reset values and timing figures of the top-off block
`ifndef CTOC_CONSTS_VH
`define CTOC_CONSTS_VH

`define CTOC_ADDR_TOPOFF_BATT_SYS_OVERCURRENT 8'h19
`define CTOC_ADDR_TERM_VOLT 8'h1a

`define CTOC_ITH_LSB 0
`define CTOC_ITH_MSB 2
`define CTOC_DUR_LSB 3
`define CTOC_DUR_MSB 5
`define CTOC_DBSEL_BIT 6
`define CTOC_TRACK_BIT 7
`define CTOC_CV_MSB 5
`define CTOC_SPARE_LSB 6

`define CTOC_RST_ITH 3'h0
`define CTOC_RST_DUR 3'h3
`define CTOC_RST_DBSEL 1'h0
`define CTOC_RST_TRACK 1'h1
`define CTOC_RST_CV 6'h00
`define CTOC_RST_SPARE 2'h0

// threshold in mA: base, step per code, ceiling code
`define CTOC_ITH_BASE_MA 13'h064
`define CTOC_ITH_STEP_MA 13'h064
`define CTOC_ITH_MAX_CODE 3'h5
// top-off duration step per code, in minutes
`define CTOC_DUR_STEP_MIN 7'h0a

// debounce times in ms and clock rate in kHz
`define CTOC_DB_SHORT_MS 6
`define CTOC_DB_LONG_MS 100
`define CTOC_CLK_KHZ 25000
`define CTOC_MIN_S 60

// detail status codes reported to the host
`define CTOC_DTLS_IDLE 4'h0
`define CTOC_DTLS_FAST 4'h3
`define CTOC_DTLS_TOPOFF 4'h4
`define CTOC_DTLS_DONE 4'h5
`define CTOC_DTLS_BATT_SYS_OVERCURRENT 4'h8

`endif

// *** ctoc_topoff_regs.v ***
// top-off / overcurrent configuration registers and charge sequencing
`include "ctoc_consts.vh"

// Functional notes
// - in constant-voltage fast charge, drop into top-off once current decays to the threshold.
// - entering top-off from fast charge pulses the charger event interrupt.
// - after entering top-off, the detail status reports top-off.
// - entering top-off starts a timer of ten minutes per code of bits 5:3 (one minute for code 0), reset code 3.
// - bits 2:0 select the threshold, 100 mA plus 100 mA per code, reset code 0.
// - reading the threshold field returns the threshold actually in effect.
// - bit 6 picks a 6 ms or 100 ms battery-to-system overcurrent debounce.
// - overcurrent lasting the debounce time disables the charger.
// - termination voltage reads the effective code, or the zone code when compliance is on.
module ctoc_topoff_regs #(
    parameter DB_SHORT_CYC = `CTOC_DB_SHORT_MS * `CTOC_CLK_KHZ,
    parameter DB_LONG_CYC = `CTOC_DB_LONG_MS * `CTOC_CLK_KHZ,
    parameter CYC_PER_MIN = `CTOC_MIN_S * 1000 * `CTOC_CLK_KHZ
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire charge_enable,
    input wire cv_regulation,
    input wire [12:0] charge_current_ma,
    input wire batt_sys_overcurrent,
    input wire temp_zone_compliance_enable,
    input wire [5:0] zone_cv_code,
    output reg charger_on,
    output reg charger_event_irq,
    output reg [3:0] charger_detail_status,
    output reg system_tracking_disable,
    output reg [5:0] termination_voltage_code
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_FAST = 5'b00010;
    localparam ST_TOPOFF = 5'b00100;
    localparam ST_DONE = 5'b01000;
    localparam ST_BATT_SYS_OVERCURRENT = 5'b10000;

    // threshold in mA for a top-off current code
    function [12:0] ith_ma;
        input [2:0] code;
        begin
            ith_ma = `CTOC_ITH_BASE_MA + `CTOC_ITH_STEP_MA * {10'h000, code};
        end
    endfunction

    reg [2:0] topoff_current_threshold_reg;
    reg [2:0] topoff_duration_reg;
    reg batt_sys_overcurrent_debounce_sel_reg;
    reg [5:0] cv_code_reg;
    reg [1:0] spare_bits_reg;
    reg [2:0] ith_eff_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [31:0] db_cnt_reg;
    reg [31:0] min_pre_reg;
    reg [6:0] min_cnt_reg;
    reg [6:0] min_goal_reg;
    // two-stage synchronisers for analog-side inputs
    reg en_s1_reg, en_s2_reg, cv_s1_reg, cv_s2_reg, oc_s1_reg, oc_s2_reg;
    reg zone_s1_reg, zone_s2_reg;
    reg [12:0] cur_s1_reg, cur_s2_reg, cur_s3_reg, cur_ok_reg;
    reg [5:0] zcv_s1_reg, zcv_s2_reg, zcv_s3_reg, zcv_ok_reg;

    wire wr_cfg = reg_wr && (reg_addr == `CTOC_ADDR_TOPOFF_BATT_SYS_OVERCURRENT);
    wire wr_cv = reg_wr && (reg_addr == `CTOC_ADDR_TERM_VOLT);
    wire [31:0] db_goal = batt_sys_overcurrent_debounce_sel_reg ?
        DB_LONG_CYC : DB_SHORT_CYC;
    wire db_hit = oc_s2_reg && (db_cnt_reg >= db_goal - 32'h1);
    wire min_tick = (min_pre_reg >= CYC_PER_MIN - 32'h1);
    wire timer_done = min_tick && (min_cnt_reg + 7'h01 >= min_goal_reg);
    wire [12:0] ith_ma_w = ith_ma(ith_eff_reg);
    wire ith_cross = cv_s2_reg && (cur_ok_reg <= ith_ma_w);
    // zone code governs the termination voltage while compliance is on
    wire [5:0] cv_eff = zone_s2_reg ? zcv_ok_reg : cv_code_reg;
    // clamp codes above the ceiling, they all mean the top threshold
    wire [2:0] ith_wr_code = (reg_wdata[`CTOC_ITH_MSB:`CTOC_ITH_LSB] >
        `CTOC_ITH_MAX_CODE) ? `CTOC_ITH_MAX_CODE :
        reg_wdata[`CTOC_ITH_MSB:`CTOC_ITH_LSB];

    // synchronisers: first stage read only by second
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            cv_s1_reg <= 1'b0;
            cv_s2_reg <= 1'b0;
            oc_s1_reg <= 1'b0;
            oc_s2_reg <= 1'b0;
            zone_s1_reg <= 1'b0;
            zone_s2_reg <= 1'b0;
            cur_s1_reg <= 13'h1fff;
            cur_s2_reg <= 13'h1fff;
            zcv_s1_reg <= 6'h00;
            zcv_s2_reg <= 6'h00;
            cur_s3_reg <= 13'h1fff;
            cur_ok_reg <= 13'h1fff;
            zcv_s3_reg <= 6'h00;
            zcv_ok_reg <= 6'h00;
        end
        else
        begin
            en_s1_reg <= charge_enable;
            en_s2_reg <= en_s1_reg;
            cv_s1_reg <= cv_regulation;
            cv_s2_reg <= cv_s1_reg;
            oc_s1_reg <= batt_sys_overcurrent;
            oc_s2_reg <= oc_s1_reg;
            zone_s1_reg <= temp_zone_compliance_enable;
            zone_s2_reg <= zone_s1_reg;
            cur_s1_reg <= charge_current_ma;
            cur_s2_reg <= cur_s1_reg;
            zcv_s1_reg <= zone_cv_code;
            zcv_s2_reg <= zcv_s1_reg;
            // multi-bit words pass only after two equal samples, no tearing
            cur_s3_reg <= cur_s2_reg;
            zcv_s3_reg <= zcv_s2_reg;
            if (cur_s2_reg == cur_s3_reg)
                cur_ok_reg <= cur_s2_reg;
            if (zcv_s2_reg == zcv_s3_reg)
                zcv_ok_reg <= zcv_s2_reg;
        end
    end

    // host-writable fields
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            topoff_current_threshold_reg <= `CTOC_RST_ITH;
            topoff_duration_reg <= `CTOC_RST_DUR;
            batt_sys_overcurrent_debounce_sel_reg <= `CTOC_RST_DBSEL;
            system_tracking_disable <= `CTOC_RST_TRACK;
            cv_code_reg <= `CTOC_RST_CV;
            spare_bits_reg <= `CTOC_RST_SPARE;
        end
        else
        begin
            if (wr_cfg)
            begin
                topoff_current_threshold_reg <= ith_wr_code;
                topoff_duration_reg <= reg_wdata[`CTOC_DUR_MSB:`CTOC_DUR_LSB];
                batt_sys_overcurrent_debounce_sel_reg <=
                    reg_wdata[`CTOC_DBSEL_BIT];
                system_tracking_disable <= reg_wdata[`CTOC_TRACK_BIT];
            end
            if (wr_cv)
            begin
                cv_code_reg <= reg_wdata[`CTOC_CV_MSB:0];
                spare_bits_reg <= reg_wdata[7:`CTOC_SPARE_LSB];
            end
        end
    end

    // threshold in effect: frozen during top-off; used by the top-off entry test and by the threshold read-back
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            ith_eff_reg <= `CTOC_RST_ITH;
        else if (state_reg != ST_TOPOFF)
            ith_eff_reg <= topoff_current_threshold_reg;
    end

    // charge sequencing
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (en_s2_reg)
                    state_next = ST_FAST;
            ST_FAST:
                if (ith_cross)
                    state_next = ST_TOPOFF;
            ST_TOPOFF:
                if (timer_done)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_DONE;
            ST_BATT_SYS_OVERCURRENT:
                state_next = ST_BATT_SYS_OVERCURRENT;
            default:
                state_next = ST_IDLE;
        endcase
        // disabling drops everything; overcurrent latches off until re-enable
        if (!en_s2_reg)
            state_next = ST_IDLE;
        else if (db_hit && state_reg != ST_IDLE)
            state_next = ST_BATT_SYS_OVERCURRENT;
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // overcurrent debounce, restarts whenever the condition drops
    always @(posedge ref_clk)
    begin
        if (!rst_n || !oc_s2_reg || db_hit)
            db_cnt_reg <= 32'h0;
        else
            db_cnt_reg <= db_cnt_reg + 32'h1;
    end

    // top-off timer: minute prescaler plus minute counter
    always @(posedge ref_clk)
    begin
        if (!rst_n || state_reg != ST_TOPOFF)
        begin
            min_pre_reg <= 32'h0;
            min_cnt_reg <= 7'h00;
        end
        else if (min_tick)
        begin
            min_pre_reg <= 32'h0;
            min_cnt_reg <= min_cnt_reg + 7'h01;
        end
        else
            min_pre_reg <= min_pre_reg + 32'h1;
    end

    // duration sampled at entry; zero code still waits one minute minimum
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            min_goal_reg <= 7'h01;
        else if (state_reg == ST_FAST && state_next == ST_TOPOFF)
            min_goal_reg <= (topoff_duration_reg == 3'h0) ? 7'h01 :
                `CTOC_DUR_STEP_MIN * {4'h0, topoff_duration_reg};
    end

    // status, event and power outputs, all registered
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            charger_on <= 1'b0;
            charger_event_irq <= 1'b0;
            charger_detail_status <= `CTOC_DTLS_IDLE;
            termination_voltage_code <= `CTOC_RST_CV;
        end
        else
        begin
            charger_on <= (state_next == ST_FAST) ||
                (state_next == ST_TOPOFF);
            charger_event_irq <= (state_reg == ST_FAST) &&
                (state_next == ST_TOPOFF);
            case (state_next)
                ST_FAST: charger_detail_status <= `CTOC_DTLS_FAST;
                ST_TOPOFF: charger_detail_status <= `CTOC_DTLS_TOPOFF;
                ST_DONE: charger_detail_status <= `CTOC_DTLS_DONE;
                ST_BATT_SYS_OVERCURRENT: charger_detail_status <= `CTOC_DTLS_BATT_SYS_OVERCURRENT;
                default: charger_detail_status <= `CTOC_DTLS_IDLE;
            endcase
            termination_voltage_code <= cv_eff;
        end
    end

    // read port: one cycle after the strobe; unmapped reads as zero
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == `CTOC_ADDR_TOPOFF_BATT_SYS_OVERCURRENT)
                reg_rdata <= {system_tracking_disable,
                    batt_sys_overcurrent_debounce_sel_reg,
                    topoff_duration_reg, ith_eff_reg};
            else if (reg_addr == `CTOC_ADDR_TERM_VOLT)
                reg_rdata <= {spare_bits_reg, cv_eff};
            else
                reg_rdata <= 8'h00;
        end
    end

endmodule

// *** ctoc_chk_assertions.sv ***
// concurrent checks on the top-off register block ports
`include "ctoc_consts.vh"
module ctoc_chk (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire charger_on,
    input wire charger_event_irq,
    input wire [3:0] charger_detail_status,
    input wire system_tracking_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_irq_single_cycle: assert property (
        charger_event_irq |=> !charger_event_irq)
        else $error("event pulse longer than one cycle");
    a_irq_from_fast: assert property (
        charger_event_irq |-> $past(charger_detail_status) == `CTOC_DTLS_FAST)
        else $error("event without prior fast charge");
    a_irq_shows_topoff: assert property (
        charger_event_irq |-> charger_detail_status == `CTOC_DTLS_TOPOFF)
        else $error("event without top-off status");
    a_topoff_keeps_on: assert property (
        charger_detail_status == `CTOC_DTLS_TOPOFF |-> charger_on)
        else $error("charger off during top-off");
    a_done_stops_charge: assert property (
        charger_detail_status == `CTOC_DTLS_DONE |-> !charger_on)
        else $error("charger on in done state");
    a_batt_sys_overcurrent_stops_charge: assert property (
        charger_detail_status == `CTOC_DTLS_BATT_SYS_OVERCURRENT |-> !charger_on)
        else $error("charger on after overcurrent");
    a_ith_read_clamp: assert property (
        reg_rd && reg_addr == 8'h19 |=> reg_rdata[2:0] <= 3'h5)
        else $error("threshold code above ceiling");
    a_track_read_match: assert property (
        reg_rd && !reg_wr && reg_addr == 8'h19
        |=> reg_rdata[7] == system_tracking_disable)
        else $error("tracking bit read differs from output");
endmodule

// *** ctoc_host.sv ***
// host-side model driving the strobed register port
module ctoc_host (
    input wire ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus shows the inverted address; write data is inverted only after a write and left as is by a read
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'hff;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    // data is taken just after the edge that registered it
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 v = reg_rdata;
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the top-off configuration block
`include "ctoc_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_n, en, cv, ovc, tz;
    logic [12:0] cur;
    logic [5:0] zone;
    logic [7:0] d;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, on, irq, track;
    wire [3:0] dtls;
    wire [5:0] term;
    int err_total, samples_checked, n;
    // address, write data, expected read-back
    logic [23:0] rows [5] = '{24'h198a8a, 24'h190705, 24'h197e7d,
        24'h1affff, 24'h205500};
    ctoc_host host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    // short counts keep the timer and debounce runs brief
    ctoc_topoff_regs #(.DB_SHORT_CYC(6), .DB_LONG_CYC(100),
        .CYC_PER_MIN(10)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .charge_enable(en), .cv_regulation(cv),
        .charge_current_ma(cur), .batt_sys_overcurrent(ovc),
        .temp_zone_compliance_enable(tz), .zone_cv_code(zone),
        .charger_on(on), .charger_event_irq(irq),
        .charger_detail_status(dtls), .system_tracking_disable(track),
        .termination_voltage_code(term));
    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task chk(input string s, input logic [12:0] seen, input logic [12:0] e);
        samples_checked++;
        if (seen !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, e, seen);
        end
    endtask
    task wt(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog well past the roughly 340-cycle run
    initial
    begin
        #100000;
        err_total++;
        conclude;
    end
    // main sequence
    initial
    begin
        {rst_n, en, cv, ovc, tz} = 5'h00;
        cur = 13'h000;
        zone = 6'h15;
        wt(3);
        rst_n <= 1'b1;
        #1 chk("track", track, 1'h1);
        host.rd(8'h19, d);
        chk("cfg reset", d, 8'h98);
        host.rd(8'h1a, d);
        chk("cv reset", d, 8'h00);
        foreach (rows[i])
        begin
            host.wr(rows[i][23:16], rows[i][15:8]);
            host.rd(rows[i][23:16], d);
            chk("readback", d, rows[i][7:0]);
        end
        wt(4);
        #1 chk("term", term, 6'h3f);
        wt(1);
        tz <= 1'b1;
        wt(5);
        #1 chk("zone term", term, 6'h15);
        host.rd(8'h1a, d);
        chk("zone read", d, 8'hd5);
        host.wr(8'h19, 8'h0a);
        tz <= 1'b0;
        en <= 1'b1;
        cur <= 13'h0190;
        wt(6);
        cv <= 1'b1;
        wt(6);
        #1 chk("above threshold", dtls, `CTOC_DTLS_FAST);
        wt(1);
        cur <= 13'h012c;
        n = 0;
        while (irq !== 1'b1 && n < 10)
        begin
            wt(1);
            #1 n++;
        end
        chk("irq", irq, 1'h1);
        chk("topoff", dtls, `CTOC_DTLS_TOPOFF);
        host.wr(8'h19, 8'h0c);
        host.rd(8'h19, d);
        chk("ith in effect", d, 8'h0a);
        wt(80);
        #1 chk("timer", dtls, `CTOC_DTLS_TOPOFF);
        n = 0;
        while (dtls !== `CTOC_DTLS_DONE && n < 40)
        begin
            wt(1);
            #1 n++;
        end
        chk("done", dtls, `CTOC_DTLS_DONE);
        chk("done off", on, 1'h0);
        // overcurrent: long debounce, then short
        wt(1);
        en <= 1'b0;
        cur <= 13'h07d0;
        host.wr(8'h19, 8'h4a);
        wt(3);
        en <= 1'b1;
        wt(6);
        ovc <= 1'b1;
        wt(95);
        #1 chk("long db", dtls, `CTOC_DTLS_FAST);
        wt(20);
        #1 chk("batt_sys_overcurrent", dtls, `CTOC_DTLS_BATT_SYS_OVERCURRENT);
        chk("batt_sys_overcurrent off", on, 1'h0);
        wt(1);
        en <= 1'b0;
        ovc <= 1'b0;
        host.wr(8'h19, 8'h0a);
        wt(3);
        en <= 1'b1;
        wt(6);
        ovc <= 1'b1;
        wt(12);
        #1 chk("short db", dtls, `CTOC_DTLS_BATT_SYS_OVERCURRENT);
        // mid-run reset, then a zero-code top-off lasting one minute
        wt(1);
        rst_n <= 1'b0;
        en <= 1'b0;
        ovc <= 1'b0;
        cur <= 13'h0064;
        wt(3);
        rst_n <= 1'b1;
        #1 chk("rst dtls", dtls, `CTOC_DTLS_IDLE);
        host.rd(8'h19, d);
        chk("rst cfg", d, 8'h98);
        host.wr(8'h19, 8'h00);
        en <= 1'b1;
        wt(8);
        #1 chk("one minute", dtls, `CTOC_DTLS_TOPOFF);
        wt(10);
        #1 chk("zero code done", dtls, `CTOC_DTLS_DONE);
        conclude;
    end
endmodule
bind ctoc_topoff_regs ctoc_chk chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .charger_on(charger_on),
    .charger_event_irq(charger_event_irq),
    .charger_detail_status(charger_detail_status),
    .system_tracking_disable(system_tracking_disable));
